/* hw/constgen_cfg.svh */
// Offsets, field positions, reset values and constants of the B operand
// constant generator; included by operand_constant_generator only, not by the package or selector_pair.
// Behaviour
// - Constants reach B only for the ten constant micro-instructions.
// - Four element pairs; each element two 4-input selectors, shared selects.
// - Each pair makes bit pairs eight apart, pair zero gives bits 0,1,8,9.
// - Outputs form word bits, byte top bits or nibble top bits per opcode.
// - Load-constant instructions select 00: supply on bits 0-14, force on 15.
// - Force bit low for zero and minus one, high for plus one, minus two.
// - Replicate, entry byte and both-bytes set-bit drive selects 1 then 0.
// - Set-bit with designators 0.0, 1.0, 0.1 drive selects 0 then 1.
// - Decimal correction drives both selects to 1, choosing correction input.
// - Fan-in inverts selector outputs under load enable: 0000 or 0001.
// - True form for zero and plus one, complement for minus one, minus two.
// - B holds zero, all ones, plus one or minus two respectively.
// - Upper-byte entry clears bits 0-7, loads N there, keeps bits 8-15.
// - Lower-byte entry clears both bytes, loads N into bits 8-15.
// - Replicate copies 4-bit X into all four nibbles, both byte clocks on.
// - Set-bit 0.0, 1.0, 0.1: code top bit picks byte, low three bits decode one-of-eight.
`ifndef CONSTGEN_CFG_SVH
`define CONSTGEN_CFG_SVH

// Register byte offsets
`define CG_OFS_EXEC     12'h000
`define CG_OFS_FIELDS   12'h004
`define CG_OFS_BREG     12'h008
`define CG_OFS_STATUS   12'h00c

// Micro-instruction word fields (EXEC)
`define CG_OP_LSB       0
`define CG_DES_A_BIT    4
`define CG_DES_B_BIT    5
`define CG_X_LSB        8

// Operand fields (FIELDS)
`define CG_N_LSB        0
`define CG_R1_LSB       8
`define CG_R2_LSB       12
`define CG_PROC_LSB     16
`define CG_CORR_LSB     20

// Status fields (STATUS)
`define CG_ST_OUT_LSB   0
`define CG_ST_SEL_LSB   16
`define CG_ST_UCLK_BIT  18
`define CG_ST_LCLK_BIT  19
`define CG_ST_LOAD_BIT  20

// Reset values
`define CG_EXEC_RST     12'h000
`define CG_FIELDS_RST   24'h00_0000
`define CG_BREG_RST     16'h0000

// Decimal correction nibbles
`define CG_CORR_SUB     4'hd
`define CG_CORR_ADD     4'h3

`endif

/* hw/constgen_pkg.sv */
// Types shared by the constant generator and its selector pairs.
// Assumes constgen_cfg.svh is on the include path.
`default_nettype none
package constgen_pkg;

   typedef enum logic [3:0]
   {
      op_none               = 4'h0,
      load_zero             = 4'h1,
      load_minus_one        = 4'h2,
      load_plus_one         = 4'h3,
      load_minus_two        = 4'h4,
      set_bit_true          = 4'h5,
      set_bit_complement    = 4'h6,
      enter_upper_byte      = 4'ha,
      enter_lower_byte      = 4'hb,
      replicate_nibble      = 4'hc,
      decimal_correction    = 4'hd
   } opcode_type;

   // Select pair as {const_select_0, const_select_1}
   typedef enum logic [1:0]
   {
      sel_supply   = 2'b00,
      sel_bitsel   = 2'b01,
      sel_entry    = 2'b10,
      sel_decimal  = 2'b11
   } select_type;

   typedef struct packed
   {
      logic [3:0] x_field;
      logic [1:0] spare;
      logic       des_b;
      logic       des_a;
      opcode_type opcode;
   } instr_type;

   typedef struct packed
   {
      logic [3:0] corr_sel;
      logic       spare;
      logic [2:0] proc_id;
      logic [3:0] r2;
      logic [3:0] r1;
      logic [7:0] n_field;
   } fields_type;

   // Four selector sources, complement form, document bit order
   typedef struct packed
   {
      logic [15:0] supply;
      logic [15:0] bitsel;
      logic [15:0] entry;
      logic [15:0] decimal;
   } sources_type;

endpackage : constgen_pkg
`default_nettype wire

/* hw/selector_pair.sv */
// One pair of selector elements: four 4-input selectors per element pair,
// producing bits 2k, 2k+1, 2k+8 and 2k+9 (document order, bit 0 = MSB).
// Assumes the shared select pair is stable during the load cycle.
`timescale 1ns/1ps
`default_nettype none
module selector_pair
#(
   parameter int unsigned PAIR = 0
)
(
   // Sources and selects
   input  wire constgen_pkg::sources_type src,
   input  wire logic [1:0]                sel,
   // Four selected bits: {2k, 2k+1, 2k+8, 2k+9}
   output logic [3:0]                     q
);

   localparam int unsigned LO = 2 * PAIR;
   localparam int unsigned HI = 2 * PAIR + 8;

   logic [3:0] s_sup;
   logic [3:0] s_bit;
   logic [3:0] s_ent;
   logic [3:0] s_dec;

   assign s_sup = {src.supply[LO],  src.supply[LO+1],
                   src.supply[HI],  src.supply[HI+1]};
   assign s_bit = {src.bitsel[LO],  src.bitsel[LO+1],
                   src.bitsel[HI],  src.bitsel[HI+1]};
   assign s_ent = {src.entry[LO],   src.entry[LO+1],
                   src.entry[HI],   src.entry[HI+1]};
   assign s_dec = {src.decimal[LO], src.decimal[LO+1],
                   src.decimal[HI], src.decimal[HI+1]};

   // Both elements share one select pair
   always_comb
   begin
      unique case (sel)
         2'b00:   q = s_sup;
         2'b01:   q = s_bit;
         2'b10:   q = s_ent;
         2'b11:   q = s_dec;
      endcase
   end

endmodule : selector_pair
`default_nettype wire

/* hw/operand_constant_generator.sv */
// Constant generator for the B operand register with an APB register file.
// A write to EXEC issues one micro-instruction; its constant loads B at
// that same edge. Assumes an APB master on pclk; no other bus masters.
`timescale 1ns/1ps
`default_nettype none
`include "constgen_cfg.svh"
module operand_constant_generator
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // B operand register, numeric value (bit 15 = MSB)
   output logic [15:0]      b_value
);

   // Register state
   constgen_pkg::instr_type  exec_r;
   constgen_pkg::fields_type fields_r;
   logic [15:0]              b_r;
   logic [15:0]              out_r;
   logic [1:0]               sel_r;
   logic                     uclk_r;
   logic                     lclk_r;
   logic                     load_r;

   // Bus decode
   logic                     acc;
   logic                     wr;
   logic                     hit_exec;
   logic                     hit_fields;
   logic                     hit_breg;
   logic                     hit_status;
   logic                     mapped;

   // Current micro-instruction (combinational from the write data)
   constgen_pkg::instr_type  cur;
   logic                     issue;

   // Decode outputs
   logic                     const_select_0;
   logic                     const_select_1;
   logic                     force_bit;
   logic                     constant_load_enable;
   logic                     upper_byte_clock_enable;
   logic                     lower_byte_clock_enable;
   logic                     clear_upper;
   logic                     clear_lower;
   logic                     complement_form;

   // Datapath (document order: index 0 = MSB)
   constgen_pkg::sources_type src;
   logic [15:0]              constant_output;
   logic [15:0]              inverted;
   logic [15:0]              stored;
   logic [15:0]              b_nxt;
   logic [3:0]               bit_code;
   logic [7:0]               bit_onehot;
   logic [7:0]               proc_onehot;
   logic [15:0]              entry_field_input;
   logic [15:0]              bit_select_input;
   logic [15:0]              decimal_digit_input;
   logic [15:0]              n_rev;
   logic [15:0]              corr_num;

   // Document order to numeric value
   function automatic logic [15:0] reverse16(input logic [15:0] v);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < 16; i++)
      begin
         r[i] = v[15-i];
      end
      return r;
   endfunction : reverse16

   assign acc        = psel & penable;
   assign wr         = acc & pwrite;
   assign hit_exec   = (paddr == `CG_OFS_EXEC);
   assign hit_fields = (paddr == `CG_OFS_FIELDS);
   assign hit_breg   = (paddr == `CG_OFS_BREG);
   assign hit_status = (paddr == `CG_OFS_STATUS);
   assign mapped     = hit_exec | hit_fields | hit_breg | hit_status;

   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   assign cur   = constgen_pkg::instr_type'(pwdata[11:0]);
   assign issue = wr & hit_exec;

   // Select pair and control decode from the issued word
   always_comb
   begin
      const_select_0          = 1'b0;
      const_select_1          = 1'b0;
      force_bit               = 1'b0;
      constant_load_enable    = 1'b0;
      upper_byte_clock_enable = 1'b0;
      lower_byte_clock_enable = 1'b0;
      clear_upper             = 1'b0;
      clear_lower             = 1'b0;
      complement_form         = 1'b0;
      if (issue)
      begin
         unique case (cur.opcode)
            constgen_pkg::load_zero,
            constgen_pkg::load_minus_one,
            constgen_pkg::load_plus_one,
            constgen_pkg::load_minus_two:
            begin
               const_select_0 = 1'b0;
               const_select_1 = 1'b0;
               force_bit = (cur.opcode == constgen_pkg::load_plus_one) |
                           (cur.opcode == constgen_pkg::load_minus_two);
               complement_form =
                  (cur.opcode == constgen_pkg::load_minus_one) |
                  (cur.opcode == constgen_pkg::load_minus_two);
               constant_load_enable    = 1'b1;
               upper_byte_clock_enable = 1'b1;
               lower_byte_clock_enable = 1'b1;
            end
            constgen_pkg::set_bit_true,
            constgen_pkg::set_bit_complement:
            begin
               constant_load_enable = 1'b1;
               complement_form =
                  (cur.opcode == constgen_pkg::set_bit_complement);
               if (cur.des_a & cur.des_b)
               begin
                  const_select_0          = 1'b1;
                  const_select_1          = 1'b0;
                  upper_byte_clock_enable = 1'b1;
                  lower_byte_clock_enable = 1'b1;
               end
               else
               begin
                  const_select_0          = 1'b0;
                  const_select_1          = 1'b1;
                  upper_byte_clock_enable = ~bit_code[3];
                  lower_byte_clock_enable = bit_code[3];
               end
            end
            constgen_pkg::enter_upper_byte:
            begin
               const_select_0          = 1'b1;
               constant_load_enable    = 1'b1;
               clear_upper             = 1'b1;
               upper_byte_clock_enable = 1'b1;
            end
            constgen_pkg::enter_lower_byte:
            begin
               const_select_0          = 1'b1;
               constant_load_enable    = 1'b1;
               clear_upper             = 1'b1;
               clear_lower             = 1'b1;
               lower_byte_clock_enable = 1'b1;
            end
            constgen_pkg::replicate_nibble:
            begin
               const_select_0          = 1'b1;
               constant_load_enable    = 1'b1;
               upper_byte_clock_enable = 1'b1;
               lower_byte_clock_enable = 1'b1;
            end
            constgen_pkg::decimal_correction:
            begin
               const_select_0          = 1'b1;
               const_select_1          = 1'b1;
               constant_load_enable    = 1'b1;
               upper_byte_clock_enable = 1'b1;
               lower_byte_clock_enable = 1'b1;
            end
            default:
            begin
               constant_load_enable = 1'b0;
            end
         endcase
      end
   end

   // Bit select code: X, X or R1, X or R2
   always_comb
   begin
      unique case ({cur.des_a, cur.des_b})
         2'b10:   bit_code = cur.x_field | fields_r.r1;
         2'b01:   bit_code = cur.x_field | fields_r.r2;
         default: bit_code = cur.x_field;
      endcase
   end

   // One-of-eight decoders for bit select and active processor
   always_comb
   begin
      bit_onehot  = 8'h00;
      proc_onehot = 8'h00;
      bit_onehot[bit_code[2:0]]     = 1'b1;
      proc_onehot[fields_r.proc_id] = 1'b1;
   end

   // Source words in true form, document order
   always_comb
   begin
      entry_field_input = 16'h0000;
      unique case (cur.opcode)
         constgen_pkg::replicate_nibble:
            entry_field_input = reverse16({4{cur.x_field}});
         constgen_pkg::enter_upper_byte,
         constgen_pkg::enter_lower_byte:
            entry_field_input = {2{n_rev[15:8]}};
         constgen_pkg::set_bit_true,
         constgen_pkg::set_bit_complement:
            entry_field_input = {2{proc_onehot}};
         default:
            entry_field_input = 16'h0000;
      endcase
   end

   assign bit_select_input = {2{bit_onehot}};
   assign n_rev            = reverse16({8'h00, fields_r.n_field});

   // Each nibble picks subtract or add correction
   generate
      for (genvar g = 0; g < 4; g++)
      begin : g_corr
         assign corr_num[4*g +: 4] =
            fields_r.corr_sel[g] ? `CG_CORR_SUB : `CG_CORR_ADD;
      end
   endgenerate
   assign decimal_digit_input = reverse16(corr_num);

   // Sources enter the selectors complemented; fan-in restores them
   assign src.supply  = {~force_bit, 15'h7fff};
   assign src.bitsel  = ~bit_select_input;
   assign src.entry   = ~entry_field_input;
   assign src.decimal = ~decimal_digit_input;

   // Four selector pairs, bits eight apart
   generate
      for (genvar k = 0; k < 4; k++)
      begin : g_pair
         logic [3:0] q;
         selector_pair
         #(
            .PAIR (k)
         )
         u_pair
         (
            .src (src),
            .sel ({const_select_0, const_select_1}),
            .q   (q)
         );
         assign constant_output[2*k]     = q[3];
         assign constant_output[2*k+1]   = q[2];
         assign constant_output[2*k+8]   = q[1];
         assign constant_output[2*k+9]   = q[0];
      end
   endgenerate

   // Fan-in inversion and true or complement storage
   assign inverted = constant_load_enable ? ~constant_output
                                          : 16'h0000;
   assign stored   = complement_form ? ~inverted : inverted;

   // Byte clocks load, clears zero an unclocked byte
   always_comb
   begin
      b_nxt = b_r;
      if (clear_upper)
      begin
         b_nxt[7:0] = 8'h00;
      end
      if (clear_lower)
      begin
         b_nxt[15:8] = 8'h00;
      end
      if (upper_byte_clock_enable)
      begin
         b_nxt[7:0] = stored[7:0];
      end
      if (lower_byte_clock_enable)
      begin
         b_nxt[15:8] = stored[15:8];
      end
   end

   // B operand register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         b_r <= `CG_BREG_RST;
      end
      else if (issue)
      begin
         b_r <= b_nxt;
      end
      else if (wr & hit_breg)
      begin
         b_r <= reverse16(pwdata[15:0]);
      end
   end

   // Micro-instruction and operand field registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         exec_r   <= constgen_pkg::instr_type'(`CG_EXEC_RST);
         fields_r <= constgen_pkg::fields_type'(`CG_FIELDS_RST);
      end
      else
      begin
         if (issue)
         begin
            exec_r <= cur;
         end
         if (wr & hit_fields)
         begin
            fields_r <= constgen_pkg::fields_type'(pwdata[23:0]);
         end
      end
   end

   // Snapshot of the last issue for status
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_r  <= 16'h0000;
         sel_r  <= 2'b00;
         uclk_r <= 1'b0;
         lclk_r <= 1'b0;
         load_r <= 1'b0;
      end
      else if (issue)
      begin
         out_r  <= constant_output;
         sel_r  <= {const_select_0, const_select_1};
         uclk_r <= upper_byte_clock_enable;
         lclk_r <= lower_byte_clock_enable;
         load_r <= constant_load_enable;
      end
   end

   // Read mux
   always_comb
   begin
      prdata = 32'h0000_0000;
      if (acc & ~pwrite)
      begin
         if (hit_exec)
         begin
            prdata[11:0] = exec_r;
         end
         if (hit_fields)
         begin
            prdata[23:0] = fields_r;
         end
         if (hit_breg)
         begin
            prdata[15:0] = reverse16(b_r);
         end
         if (hit_status)
         begin
            prdata[`CG_ST_OUT_LSB +: 16] = out_r;
            prdata[`CG_ST_SEL_LSB +: 2]  = sel_r;
            prdata[`CG_ST_UCLK_BIT]      = uclk_r;
            prdata[`CG_ST_LCLK_BIT]      = lclk_r;
            prdata[`CG_ST_LOAD_BIT]      = load_r;
         end
      end
   end

   assign b_value = reverse16(b_r);

endmodule : operand_constant_generator
`default_nettype wire

/* bench/constgen_properties.sv */
// Concurrent checks on the constant generator's ports.
// Assumes one pclk domain with presetn as its asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module constgen_properties
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // B operand
   input wire logic [15:0] b_value
);
   logic [7:0] n_r;

   // Entry field as last written
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         n_r <= 8'h00;
      else if (psel && penable && pready && pwrite && paddr == 12'h004)
         n_r <= pwdata[7:0];
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_exec_wr;
      psel && penable && pready && pwrite && paddr == 12'h000;
   endsequence

   sequence s_issue(logic [3:0] op);
      s_exec_wr ##0 pwdata[3:0] == op;
   endsequence

   a_load_zero:
   assert property (s_issue(constgen_pkg::load_zero) |=> b_value == 16'h0000)
      else $error("B not zero after load zero");
   a_minus_one:
   assert property (s_issue(constgen_pkg::load_minus_one)
      |=> b_value == 16'hffff)
      else $error("B not all ones after load minus one");
   a_plus_one:
   assert property (s_issue(constgen_pkg::load_plus_one)
      |=> b_value == 16'h0001)
      else $error("B not one after load plus one");
   a_minus_two:
   assert property (s_issue(constgen_pkg::load_minus_two)
      |=> b_value == 16'hfffe)
      else $error("B not minus two after load minus two");
   a_other_code_hold:
   assert property (s_exec_wr ##0
      !(pwdata[3:0] inside {[4'h1:4'h6], [4'ha:4'hd]})
      |=> $stable(b_value)) else $error("B changed on a code without constant");
   a_nibble_copy:
   assert property (s_issue(constgen_pkg::replicate_nibble)
      |=> b_value == {4{$past(pwdata[11:8])}}) else $error("Nibble copy wrong");
   a_upper_entry:
   assert property (s_issue(constgen_pkg::enter_upper_byte)
      |=> b_value == {n_r, $past(b_value[7:0])}) else $error("Upper entry wrong");
   a_lower_entry:
   assert property (s_issue(constgen_pkg::enter_lower_byte)
      |=> b_value == {8'h00, n_r}) else $error("Lower entry wrong");
   a_unmapped_err:
   assert property (psel && penable && paddr > 12'h00c |-> pslverr && prdata == 32'h0)
      else $error("Unmapped access not refused");
endmodule : constgen_properties

bind operand_constant_generator constgen_properties u_props
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .b_value(b_value)
);
`default_nettype wire

/* bench/instr_issuer.sv */
// Micro-instruction issuer: APB master in front of the constant generator.
// Assumes a free-running pclk; waits for pready under a bounded count.
`timescale 1ns/1ps
`default_nettype none
module instr_issuer
(
   // Clock
   input  wire logic        pclk,
   // APB master side
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'hfff;
      pwdata  = 32'h0000_0000;
   end

   // One whole transfer; tmo high when no answer came
   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err, output logic tmo);
      int n;
      n = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      tmo = (pready !== 1'b1);
      q   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released lines show no stale value
      pwrite <= ~wr;
      paddr  <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : instr_issuer
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench: issues micro-instructions over APB, reads B back.
// Assumes the issuer model and the checker bound to the design.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [11:0] EXEC = 12'h000;
   localparam logic [11:0] FLD  = 12'h004;
   localparam logic [11:0] BREG = 12'h008;
   localparam logic [11:0] STAT = 12'h00c;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] b_value;
   int          n_errors = 0;
   int          n_checks = 0;

   instr_issuer mst
   (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr)
   );
   operand_constant_generator uut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .b_value(b_value)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : check

   task automatic end_of_test;
      if (n_errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test

   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      logic tmo;
      mst.xfer(wr, a, d, q, err, tmo);
      if (tmo)
      begin
         n_errors++;
         end_of_test();
      end
   endtask : bus

   // Preload B and fields, issue, then read B and the select status
   task automatic op(input logic [15:0] pre, input logic [31:0] fld,
                     input logic [31:0] ex, input logic [15:0] exp,
                     input logic [1:0] sel);
      bus(1'b1, BREG, {16'h0000, pre});
      bus(1'b1, FLD, fld);
      bus(1'b1, EXEC, ex);
      bus(1'b0, BREG, 32'h0);
      check(q, {16'h0000, exp});
      bus(1'b0, STAT, 32'h0);
      check({30'h0, q[17:16]}, {30'h0, sel});
      check({31'h0, q[20]}, 32'h1);
   endtask : op

   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   initial
   begin
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      bus(1'b0, BREG, 32'h0);
      check(q, 32'h0);
      bus(1'b0, EXEC, 32'h0);
      check(q, 32'h0);
      op(16'h1234, 32'h0, 32'h0001, 16'h0000, 2'b00);
      op(16'h1234, 32'h0, 32'h0002, 16'hffff, 2'b00);
      op(16'h1234, 32'h0, 32'h0003, 16'h0001, 2'b00);
      op(16'h1234, 32'h0, 32'h0004, 16'hfffe, 2'b00);
      op(16'h7fff, 32'h0, 32'h0305, 16'h10ff, 2'b01);
      check({30'h0, q[19:18]}, 32'h1);
      op(16'hff7f, 32'h0, 32'h0b05, 16'hff10, 2'b01);
      op(16'h00ff, 32'h0, 32'h0306, 16'hefff, 2'b01);
      op(16'h0000, 32'h0800, 32'h0115, 16'h0040, 2'b01);
      op(16'h0000, 32'h8000, 32'h0125, 16'h0040, 2'b01);
      op(16'h0000, 32'h2_0000, 32'h0035, 16'h2020, 2'b10);
      op(16'h5a3c, 32'h00a5, 32'h000a, 16'ha53c, 2'b10);
      op(16'h5a3c, 32'h00a5, 32'h000b, 16'h00a5, 2'b10);
      op(16'h0000, 32'h0, 32'h030c, 16'h3333, 2'b10);
      op(16'h0000, 32'ha0_0000, 32'h000d, 16'hd3d3, 2'b11);
      check({30'h0, q[19:18]}, 32'h3);
      check({16'h0, q[15:0]}, 32'h3434);
      // Codes without a constant, then an unmapped place
      bus(1'b1, BREG, 32'h0000_beef);
      bus(1'b1, EXEC, 32'h0000_0000);
      bus(1'b1, EXEC, 32'h0000_0007);
      bus(1'b1, EXEC, 32'h0000_000f);
      bus(1'b1, 12'h010, 32'h0000_0001);
      check({31'h0, err}, 32'h1);
      bus(1'b0, 12'h010, 32'h0);
      check({31'h0, err}, 32'h1);
      check(q, 32'h0);
      bus(1'b0, BREG, 32'h0);
      check(q, 32'h0000_beef);
      bus(1'b0, EXEC, 32'h0);
      check(q, 32'h0000_000f);
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
